// ### hw/ebpc_pkg.sv
/*
   ebpc_pkg: constants and types shared by the external bus pin configuration logic.
   Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package ebpc_pkg;

   // ********************************************************************
   // register map
   // ********************************************************************
   localparam logic [3:0] EBPC_OFF_CTRL0   = 4'h0;
   localparam logic [3:0] EBPC_OFF_CSWAIT  = 4'h4;
   localparam logic [3:0] EBPC_OFF_MODE    = 4'h8;
   localparam logic [3:0] EBPC_OFF_PINSTAT = 4'hC;

   // ********************************************************************
   // control register fields
   // ********************************************************************
   localparam int          EBPC_THR_BIT   = 7;
   localparam int          EBPC_HIGH_BYTE_ENABLE_BIT  = 5;
   localparam int          EBPC_ASIZ_MSB  = 4;
   localparam int          EBPC_ASIZ_W    = 5;
   localparam logic [7:0]  EBPC_CTRL0_RST = 8'h37;
   localparam logic [7:0]  EBPC_CTRL0_WMASK = 8'hBF;
   localparam int          EBPC_ADDR_LINES  = 23;
   localparam int          EBPC_CS_LINES    = 4;

   // ********************************************************************
   // operating modes
   // ********************************************************************
   typedef enum logic [2:0]
   {
      EBPC_MODE_NS = 3'h0,
      EBPC_MODE_SS = 3'h1,
      EBPC_MODE_NX = 3'h2,
      EBPC_MODE_ES = 3'h3,
      EBPC_MODE_EX = 3'h4,
      EBPC_MODE_ST = 3'h5
   } ebpc_mode_type;

   localparam logic [1:0] EBPC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] EBPC_RESP_SLVERR = 2'h2;

endpackage

// ### hw/ebpc_cfg_if.sv
/*
   ebpc_cfg_if: configuration fields carried from the register file to the pin decoder.
   Assumes one clock domain; the fields are registered at the source.
*/
`timescale 1ns/1ps
interface ebpc_cfg_if;
   logic       thr_sel;
   logic       high_byte_enable;
   logic [4:0] asiz;
   logic [3:0] cs_wait;
   logic [2:0] mode;

   modport src
   (
      output thr_sel, high_byte_enable, asiz, cs_wait, mode
   );
   modport dst
   (
      input  thr_sel, high_byte_enable, asiz, cs_wait, mode
   );
endinterface

// ### hw/ebpc_decode.sv
/*
   ebpc_decode: combinational pin-use and threshold decode from mode and control fields.
   Assumes fields arrive registered; outputs are re-registered by the parent.
*/
`timescale 1ns/1ps
module ebpc_decode
   import ebpc_pkg::*;
(
   ebpc_cfg_if.dst                  cfg,
   output wire logic                data_hi_en,
   output wire logic                data_lo_en,
   output wire logic                strobe_en,
   output wire logic [22:0]         addr_en,
   output wire logic                upper_strobe_en,
   output wire logic                thr_data_lo,
   output wire logic                thr_data_hi,
   output wire logic                thr_wait,
   output wire logic                wait_en
);
   wire logic is_nx   = (cfg.mode == EBPC_MODE_NX);
   wire logic is_emu  = (cfg.mode == EBPC_MODE_ES) || (cfg.mode == EBPC_MODE_EX);
   wire logic is_full = is_emu || (cfg.mode == EBPC_MODE_ST);
   wire logic is_ext  = is_nx || is_full;
   wire logic [4:0] eff_asiz = is_full ? 5'h17 : (is_nx ? cfg.asiz : 5'h00);

   assign data_lo_en      = is_ext;
   assign data_hi_en      = is_full || (is_nx && cfg.high_byte_enable);
   assign strobe_en       = data_hi_en;
   // a nonzero effective size claims the upper byte strobe line; single-chip modes force it to zero
   assign upper_strobe_en = (eff_asiz != 5'h00) || strobe_en;

   // address line n (n>=1) is driven when the effective size exceeds n
   genvar g;
   generate
      for (g = 0; g < 23; g++)
      begin : g_addr
         if (g == 0)
         begin : g_a0
            assign addr_en[g] = 1'b0;
         end
         else
         begin : g_an
            assign addr_en[g] = (eff_asiz > 5'(g));
         end
      end
   endgenerate

   assign wait_en     = |cfg.cs_wait;
   assign thr_data_lo = is_emu || (cfg.thr_sel && (is_nx || (cfg.mode == EBPC_MODE_ST)));
   assign thr_data_hi = is_emu
                        || (cfg.thr_sel && ((is_nx && cfg.high_byte_enable)
                                            || (cfg.mode == EBPC_MODE_ST)));
   assign thr_wait    = cfg.thr_sel && wait_en
                        && (is_nx || (cfg.mode == EBPC_MODE_EX));
endmodule // ebpc_decode

// ### hw/ebpc_top.sv
/*
   ebpc_top: external bus pin configuration with an AXI4-Lite register file.
   Assumes operating mode is a synchronous input; pin enables feed a pad ring.
*/
`timescale 1ns/1ps

// Operation
// - normal expanded mode sizes and enables bus pins from the control fields
// - emulation and special test modes always give the full-width bus
// - single-chip modes give no external bus function on any pin but the wait input
// - high byte enable gates upper data lines and strobe_en; upper strobe also set by a nonzero size
// - size field counts low-aligned address lines driven; others are freed
// - size 0 drives nothing, 1 upper strobe, 2 adds address line 1
// - after reset in expanded modes address lines 1 to 22 are outputs
// - threshold bit 0 keeps standard levels outside emulation; 1 reduces only on used bus pins
// - threshold per input from bit, mode and pin enable; emulation data always reduced
// - normal expanded with bit set: low data reduced, high data if enabled
// - wait input enabled by any chip-select using it; gates its threshold
module ebpc_top
   import ebpc_pkg::*;
(
   input  wire logic                sys_clk,
   input  wire logic                rst,
   input  wire ebpc_pkg::ebpc_mode_type op_mode,
   input  wire logic [3:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [3:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output logic                     data_hi_en_ff,
   output logic                     data_lo_en_ff,
   output logic                     strobe_en_ff,
   output logic                     upper_strobe_en_ff,
   output logic [22:0]              addr_en_ff,
   output logic                     thr_data_lo_ff,
   output logic                     thr_data_hi_ff,
   output logic                     thr_wait_ff,
   output logic                     wait_en_ff
);
   import ebpc_pkg::*;

   // ********************************************************************
   // register storage
   // ********************************************************************
   logic [7:0]    ctrl0_ff;
   logic [3:0]    cswait_ff;
   logic [2:0]    mode_ff;
   logic [3:0]    awaddr_ff;
   logic          aw_held_ff;
   logic [31:0]   wdata_ff;
   logic [3:0]    wstrb_ff;
   logic          w_held_ff;

   ebpc_cfg_if cfg_bus ();

   assign cfg_bus.thr_sel = ctrl0_ff[EBPC_THR_BIT];
   assign cfg_bus.high_byte_enable    = ctrl0_ff[EBPC_HIGH_BYTE_ENABLE_BIT];
   assign cfg_bus.asiz    = ctrl0_ff[EBPC_ASIZ_MSB:0];
   assign cfg_bus.cs_wait = cswait_ff;
   assign cfg_bus.mode    = mode_ff;

   // ********************************************************************
   // write channel: address and data accepted in either order
   // ********************************************************************
   wire logic aw_take  = s_axi_awvalid && s_axi_awready;
   wire logic w_take   = s_axi_wvalid && s_axi_wready;
   wire logic aw_have  = aw_held_ff || aw_take;
   wire logic w_have   = w_held_ff || w_take;
   wire logic wr_fire  = aw_have && w_have && !s_axi_bvalid;
   wire logic [3:0]  wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
   wire logic [31:0] wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
   wire logic [3:0]  wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
   wire logic wr_ctrl0 = wr_fire && (wr_addr == EBPC_OFF_CTRL0) && wr_strb[0];
   wire logic wr_cswt  = wr_fire && (wr_addr == EBPC_OFF_CSWAIT) && wr_strb[0];
   wire logic wr_ok    = (wr_addr == EBPC_OFF_CTRL0) || (wr_addr == EBPC_OFF_CSWAIT);
   wire logic [7:0] nxt_ctrl0 = (wr_data[7:0] & EBPC_CTRL0_WMASK);

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_held_ff    <= 1'b0;
         w_held_ff     <= 1'b0;
         awaddr_ff     <= 4'h0;
         wdata_ff      <= 32'h0000_0000;
         wstrb_ff      <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= EBPC_RESP_OKAY;
      end
      else
      begin
         // ready drops once an item is held, so one write is in flight at most
         s_axi_awready <= !aw_have && !wr_fire && !s_axi_bvalid;
         s_axi_wready  <= !w_have && !wr_fire && !s_axi_bvalid;
         aw_held_ff    <= aw_have && !wr_fire;
         w_held_ff     <= w_have && !wr_fire;
         if (aw_take)
            awaddr_ff <= s_axi_awaddr;
         if (w_take)
         begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? EBPC_RESP_OKAY : EBPC_RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ********************************************************************
   // configuration registers
   // ********************************************************************
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl0_ff  <= EBPC_CTRL0_RST;
         cswait_ff <= 4'h0;
         mode_ff   <= 3'h0;
      end
      else
      begin
         mode_ff <= op_mode;
         if (wr_ctrl0)
            ctrl0_ff <= nxt_ctrl0;
         if (wr_cswt)
            cswait_ff <= wr_data[3:0];
      end
   end

   // ********************************************************************
   // read channel
   // ********************************************************************
   wire logic rd_take = s_axi_arvalid && s_axi_arready;
   logic [31:0] rd_mux;
   logic        rd_ok;

   always_comb
   begin
      rd_ok  = 1'b1;
      rd_mux = 32'h0000_0000;
      unique case (s_axi_araddr)
         EBPC_OFF_CTRL0:   rd_mux = {24'h00_0000, ctrl0_ff};
         EBPC_OFF_CSWAIT:  rd_mux = {28'h000_0000, cswait_ff};
         EBPC_OFF_MODE:    rd_mux = {29'h0000_0000, mode_ff};
         EBPC_OFF_PINSTAT: rd_mux = {addr_en_ff, data_hi_en_ff, data_lo_en_ff,
                                     strobe_en_ff, upper_strobe_en_ff, thr_data_lo_ff,
                                     thr_data_hi_ff, thr_wait_ff, wait_en_ff, 1'b0};
         default:          rd_ok  = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= EBPC_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !rd_take;
         if (rd_take)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_ok ? EBPC_RESP_OKAY : EBPC_RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ********************************************************************
   // pin decode, registered so pins change on a clean edge
   // ********************************************************************
   logic        dec_hi;
   logic        dec_lo;
   logic        dec_strb;
   logic        dec_ustrb;
   logic [22:0] dec_addr;
   logic        dec_tlo;
   logic        dec_thi;
   logic        dec_twait;
   logic        dec_wen;

   ebpc_decode u_decode
   (
      .cfg             (cfg_bus),
      .data_hi_en      (dec_hi),
      .data_lo_en      (dec_lo),
      .strobe_en       (dec_strb),
      .addr_en         (dec_addr),
      .upper_strobe_en (dec_ustrb),
      .thr_data_lo     (dec_tlo),
      .thr_data_hi     (dec_thi),
      .thr_wait        (dec_twait),
      .wait_en         (dec_wen)
   );

   // flopping the decode avoids decoder hazards reaching unchanged pins
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         data_hi_en_ff      <= 1'b0;
         data_lo_en_ff      <= 1'b0;
         strobe_en_ff       <= 1'b0;
         upper_strobe_en_ff <= 1'b0;
         addr_en_ff         <= 23'h00_0000;
         thr_data_lo_ff     <= 1'b0;
         thr_data_hi_ff     <= 1'b0;
         thr_wait_ff        <= 1'b0;
         wait_en_ff         <= 1'b0;
      end
      else
      begin
         data_hi_en_ff      <= dec_hi;
         data_lo_en_ff      <= dec_lo;
         strobe_en_ff       <= dec_strb;
         upper_strobe_en_ff <= dec_ustrb;
         addr_en_ff         <= dec_addr;
         thr_data_lo_ff     <= dec_tlo;
         thr_data_hi_ff     <= dec_thi;
         thr_wait_ff        <= dec_twait;
         wait_en_ff         <= dec_wen;
      end
   end
endmodule // ebpc_top

// ### verification/ebpc_props.sv
/*
   ebpc_props: concurrent checks on the pin enable and threshold outputs of ebpc_top.
   Assumes it is bound to ebpc_top; the pins follow op_mode two edges later.
*/
`timescale 1ns/1ps
module ebpc_props
   import ebpc_pkg::*;
(
   input wire logic                    sys_clk,
   input wire logic                    rst,
   input wire ebpc_pkg::ebpc_mode_type op_mode,
   input wire logic                    data_hi_en_ff,
   input wire logic                    data_lo_en_ff,
   input wire logic                    strobe_en_ff,
   input wire logic [22:0]             addr_en_ff,
   input wire logic                    thr_data_lo_ff,
   input wire logic                    thr_data_hi_ff,
   input wire logic                    thr_wait_ff,
   input wire logic                    wait_en_ff
);
   logic [1:0] up_ff;
   wire        up = (up_ff == 2'h3);

   // mode register may still hold its reset value on the first edges
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         up_ff <= 2'h0;
      else if (!up)
         up_ff <= up_ff + 2'h1;
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   AST_SINGLE: assert property (
      up && (op_mode inside {EBPC_MODE_NS, EBPC_MODE_SS}) |-> ##2
      addr_en_ff == 23'h0 && !data_lo_en_ff && !strobe_en_ff)
      else $error("single-chip mode left bus pins on");
   AST_FULL: assert property (
      up && (op_mode inside {EBPC_MODE_ES, EBPC_MODE_EX, EBPC_MODE_ST}) |-> ##2
      addr_en_ff == 23'h7FFFFE && data_hi_en_ff && strobe_en_ff)
      else $error("full-width bus missing");
   AST_EMU_THR: assert property (
      up && (op_mode inside {EBPC_MODE_ES, EBPC_MODE_EX}) |-> ##2
      thr_data_lo_ff && thr_data_hi_ff)
      else $error("emulation data threshold not reduced");
   AST_ES_WAIT: assert property (
      up && op_mode == EBPC_MODE_ES |-> ##2 !thr_wait_ff)
      else $error("wait threshold reduced in emulation single-chip");
   AST_WAIT_GATE: assert property (
      thr_wait_ff |-> wait_en_ff && data_lo_en_ff)
      else $error("wait threshold reduced while wait unused");
   AST_LO_USE: assert property (
      thr_data_lo_ff |-> data_lo_en_ff)
      else $error("low data threshold reduced on unused pins");
   AST_HI_HIGH_BYTE_ENABLE: assert property (
      thr_data_hi_ff |-> data_hi_en_ff)
      else $error("high data threshold reduced with high byte off");
   AST_STROBE: assert property (
      $rose(data_hi_en_ff) || $fell(data_hi_en_ff) |-> $changed(strobe_en_ff))
      else $error("byte strobes not following high byte enable");
endmodule // ebpc_props

bind ebpc_top ebpc_props chk_u (.sys_clk(sys_clk), .rst(rst), .op_mode(op_mode),
   .data_hi_en_ff(data_hi_en_ff), .data_lo_en_ff(data_lo_en_ff),
   .strobe_en_ff(strobe_en_ff), .addr_en_ff(addr_en_ff), .thr_data_lo_ff(thr_data_lo_ff),
   .thr_data_hi_ff(thr_data_hi_ff), .thr_wait_ff(thr_wait_ff), .wait_en_ff(wait_en_ff));

// ### verification/ebpc_pad_model.sv
/*
   ebpc_pad_model: far-side view of the external address pads.
   Assumes the address enables come from the registered pin outputs of ebpc_top.
*/
`timescale 1ns/1ps
module ebpc_pad_model
(
   input wire logic [22:0] addr_en,
   output logic     [4:0]  addr_cnt
);
   // a memory only sees the lines that are really driven
   assign addr_cnt = 5'($countones(addr_en));
endmodule // ebpc_pad_model

// ### verification/ext_bus_pin_config_tb_top.sv
/*
   ext_bus_pin_config_tb_top: self-checking bench for ebpc_top over AXI4-Lite.
   Assumes ebpc_props is bound to the design and ebpc_pad_model watches the pads.
*/
`timescale 1ns/1ps
module ext_bus_pin_config_tb_top;
   import ebpc_pkg::*;
   logic          sys_clk = 1'h0;
   logic          rst = 1'h1;
   ebpc_mode_type op_mode = EBPC_MODE_NX;
   logic [3:0]    awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
   logic [31:0]   wdata = 32'h0, seed = 32'h880FDF0D;
   logic          awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   wire           awready, wready, bvalid, arready, rvalid;
   wire [1:0]     bresp, rresp;
   wire [31:0]    rdata;
   wire [22:0]    addr_en;
   wire [4:0]     pad_cnt;
   int            error_cnt = 0, num_checks = 0;
   int            sz[6] = '{0, 1, 2, 22, 23, 31};
   logic [31:0]   rq[$];
   logic [1:0]    bq[$];

   always #12.5 sys_clk = ~sys_clk;

   ebpc_top dut_u (.sys_clk(sys_clk), .rst(rst), .op_mode(op_mode),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .data_hi_en_ff(), .data_lo_en_ff(), .strobe_en_ff(), .upper_strobe_en_ff(),
      .addr_en_ff(addr_en), .thr_data_lo_ff(), .thr_data_hi_ff(), .thr_wait_ff(),
      .wait_en_ff());
   ebpc_pad_model pad_u (.addr_en(addr_en), .addr_cnt(pad_cnt));

   // ********************************************************************
   // checking and expectations
   // ********************************************************************
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // pin status word: addr, hi, lo, strobes, upper strobe, thresholds, wait
   function automatic logic [31:0] exp_pins(input logic [2:0] m, input logic [7:0] c,
                                            input logic [3:0] w);
      logic        sc, emu, full, nx, hd, t;
      logic [4:0]  v;
      logic [22:0] ad;
      sc   = (m <= 3'h1);
      emu  = (m == 3'h3) || (m == 3'h4);
      full = emu || (m == 3'h5);
      nx   = (m == 3'h2);
      t    = c[7];
      v    = (c[4:0] > 5'h17) ? 5'h17 : c[4:0];
      hd   = full || (nx && c[5]);
      ad   = full ? 23'h7FFFFE : nx ? (((23'h1 << v) - 23'h1) & 23'h7FFFFE) : 23'h0;
      // upper strobe is claimed by a nonzero size field in normal expanded mode or by the high data enable hd
      return {ad, hd, !sc, hd, hd || (nx && v != 5'h0), !sc && (emu || t),
              emu || (t && ((m == 3'h5) || (nx && c[5]))),
              t && (nx || m == 3'h4) && |w, |w, 1'h0};
   endfunction

   always @(posedge sys_clk)
   begin
      if (rvalid && rready)
      begin
         chk(rdata, rq.pop_front());
         chk({30'h0, rresp}, {30'h0, EBPC_RESP_OKAY});
      end
      if (bvalid && bready)
         chk({30'h0, bresp}, {30'h0, bq.pop_front()});
   end

   // ********************************************************************
   // bus tasks
   // ********************************************************************
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      bq.push_back(r);
      @(posedge sys_clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      do
      begin
         @(posedge sys_clk);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
      end
      while (!(bvalid && bready));
      bready <= 1'h0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      rq.push_back(e);
      @(posedge sys_clk);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      do
      begin
         @(posedge sys_clk);
         if (arready)
            arvalid <= 1'h0;
      end
      while (!rvalid);
      rready <= 1'h0;
   endtask

   task automatic cfg(input logic [2:0] m, input logic [31:0] c, input logic [3:0] w);
      logic [31:0] e;
      e = exp_pins(m, c[7:0], w);
      wr(4'h0, c, EBPC_RESP_OKAY);
      wr(4'h4, {28'h0, w}, EBPC_RESP_OKAY);
      op_mode <= ebpc_mode_type'(m);
      repeat (3) @(posedge sys_clk);
      rd(4'h0, {24'h0, c[7:0] & EBPC_CTRL0_WMASK});
      rd(4'h8, {29'h0, m});
      rd(4'hC, e);
      chk({27'h0, pad_cnt}, $countones(e[31:9]));
   endtask

   // ********************************************************************
   // tests
   // ********************************************************************
   initial
   begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'h0;
      repeat (2) @(posedge sys_clk);
      rd(4'h0, {24'h0, EBPC_CTRL0_RST});
      rd(4'h4, 32'h0);
      rd(4'hC, exp_pins(3'h2, EBPC_CTRL0_RST, 4'h0));
      wr(4'h8, 32'hFF, EBPC_RESP_SLVERR);
      wr(4'hC, 32'hFF, EBPC_RESP_SLVERR);
      $display("test reset_and_readonly done");
      foreach (sz[i])
         cfg(3'h2, {24'h0, i[0], 2'h1, sz[i][4:0]}, 4'h1);
      $display("test address_size done");
      for (int m = 0; m < 6; m++)
         for (int k = 0; k < 6; k++)
         begin
            seed = lfsr(seed);
            cfg(3'(m), seed, (m < 2) ? 4'h0 : seed[11:8]);
         end
      $display("test random_modes done");
      repeat (2) @(posedge sys_clk);
      final_report;
   end

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      final_report;
   end
endmodule // ext_bus_pin_config_tb_top
